//--- hw/trhps_cfg.svh
// trhps_cfg.svh: reset values and field positions for the tone receiver port
// assumes: included by bare name, definitions only
`ifndef TRHPS_CFG_SVH
`define TRHPS_CFG_SVH
`define TRHPS_CODE_RST      4'h0
`define TRHPS_SETTLE_CYC    2
`define TRHPS_STAT_DS_BIT   2
`define TRHPS_STAT_ESTB_BIT 1
`define TRHPS_STAT_CPM_BIT  0
`endif

//--- hw/trhps_pkg.sv
// trhps_pkg.sv: types for the tone receiver host port
// assumes: compiled before the design modules
`default_nettype none
package trhps_pkg;
    typedef logic [3:0] trhps_nib_t;
    typedef enum logic [1:0] {
        TRHPS_IDLE   = 2'b00,
        TRHPS_SETTLE = 2'b01,
        TRHPS_HELD   = 2'b11
    } trhps_steer_e;
endpackage : trhps_pkg
`default_nettype wire

//--- hw/trhps_sync.sv
// trhps_sync.sv: two-flop synchroniser for a bundle of pin levels
// assumes: inputs are asynchronous to clock_in
`default_nettype none
module trhps_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule : trhps_sync
`default_nettype wire

//--- hw/trhps_top.sv
// trhps_top.sv: host nibble port and receive steering of a tone transceiver
// assumes: pins arrive asynchronously and are synchronised here; open-drain
// and tri-state wires are resolved outside from the enables (low = drive)
// Function
// - direction input picks host write or host read of the data nibble
// - accesses are honoured only while chip select is low
// - data lines float whenever chip select high or phase clock low
// - nothing depends on the phase clock toggling outside accesses
// - register select with direction picks the register reached
// - call progress plus interrupt enable: interrupt pin shows tone square
// - early detect rises as soon as a valid tone pair is found
// - early detect falls at once on any loss, no filtering
// - sense above threshold registers the pair and updates the latch
// - sense below threshold rearms for a new tone pair
// - guard drive follows early detect and the sense level
// - registration latches the 4-bit tone code into receive data
// - interrupt mode pulls interrupt pin low while delayed flag active
// - reading receive data puts the latched code on the bus
// - no detection or registration while in call progress mode
`include "trhps_cfg.svh"
`default_nettype none
module trhps_top
    import trhps_pkg::*;
#(
    parameter int SETTLE_CYC = `TRHPS_SETTLE_CYC
) (
    input  wire logic       clock_in,
    input  wire logic       reset_n_in,
    input  wire logic       read_not_write_in,
    input  wire logic       chip_select_n_in,
    input  wire logic       register_select_bit_in,
    input  wire logic       phase_clock_in,
    input  wire logic [3:0] host_data_nibble_in,
    output logic      [3:0] host_data_nibble_out,
    output logic            host_data_nibble_oe_n_out,
    input  wire logic       tone_pair_valid_in,
    input  wire logic [3:0] tone_code_in,
    input  wire logic       tone_square_in,
    input  wire logic       steering_threshold_in,
    output logic            early_tone_detect_out,
    output logic            guard_time_drive_out,
    output logic            steering_sense_guard_drive_oe_n_out,
    output logic            interrupt_or_tone_square_out,
    output logic            interrupt_or_tone_square_oe_n_out,
    output logic            delayed_steer_out,
    output logic [3:0]      host_write_data_out,
    output logic            host_write_strobe_out,
    output logic            host_write_select_out,
    input  wire logic [3:0] status_extra_in,
    input  wire logic       call_progress_mode_in,
    input  wire logic       interrupt_enable_in
);
    localparam int NS = 9;
    logic [NS-1:0] pin_sync;
    logic [3:0]    wdat_sync;
    trhps_sync #(.WIDTH(NS)) u_sync_ctl (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   ({read_not_write_in, chip_select_n_in,
                      register_select_bit_in, phase_clock_in,
                      tone_pair_valid_in, tone_square_in,
                      steering_threshold_in, call_progress_mode_in,
                      interrupt_enable_in}),
        .sync_out   (pin_sync)
    );
    trhps_sync #(.WIDTH(4)) u_sync_dat (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   (host_data_nibble_in),
        .sync_out   (wdat_sync)
    );
    logic s_rw, s_cs_n, s_rs, s_ph, s_valid, s_sq, s_thr, s_cpm, s_ien;
    assign {s_rw, s_cs_n, s_rs, s_ph, s_valid, s_sq,
            s_thr, s_cpm, s_ien} = pin_sync;

    // tone code is a sampled bus from the detector, held stable while valid
    logic [3:0] code_sync;
    trhps_sync #(.WIDTH(4)) u_sync_code (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .async_in   (tone_code_in),
        .sync_out   (code_sync)
    );

    // ---- steering ----
    trhps_steer_e state_ff, nxt_state;
    logic [3:0]   code_ff, nxt_code;
    logic         est_ff, nxt_est;
    logic         ds_ff, nxt_ds;
    logic [7:0]   cnt_ff, nxt_cnt;
    logic         wr_ff, nxt_wr;
    logic         phase_d_ff, nxt_phase_d;

    always_comb begin
        nxt_est   = s_valid && !s_cpm;
        nxt_state = state_ff;
        nxt_code  = code_ff;
        nxt_ds    = ds_ff;
        nxt_cnt   = cnt_ff;
        unique case (state_ff)
            TRHPS_IDLE: begin
                if (s_thr && !s_cpm) begin
                    nxt_code  = code_sync;
                    nxt_cnt   = 8'(SETTLE_CYC);
                    nxt_state = TRHPS_SETTLE;
                end
            end
            TRHPS_SETTLE: begin
                if (cnt_ff <= 8'h01) begin
                    nxt_ds    = 1'b1;
                    nxt_cnt   = 8'h00;
                    nxt_state = TRHPS_HELD;
                end else begin
                    nxt_cnt = cnt_ff - 8'h01;
                end
            end
            TRHPS_HELD: begin
                if (!s_thr) begin
                    nxt_ds    = 1'b0;
                    nxt_state = TRHPS_IDLE;
                end
            end
        endcase
    end

    // ---- host port ----
    logic       access;
    logic       rd_data_sel;
    logic [3:0] status_word;
    logic [3:0] nxt_rdata;
    logic [3:0] rdata_ff;
    logic [3:0] wdat_ff, nxt_wdat;
    logic       wsel_ff, nxt_wsel;

    assign access = !s_cs_n && s_ph;
    assign rd_data_sel = !s_rs;

    always_comb begin
        status_word = status_extra_in;
        status_word[`TRHPS_STAT_DS_BIT]   = ds_ff;
        status_word[`TRHPS_STAT_ESTB_BIT] = est_ff;
        status_word[`TRHPS_STAT_CPM_BIT]  = s_cpm;
        nxt_rdata   = rd_data_sel ? code_ff : status_word;
        nxt_phase_d = s_ph;
        // write taken once, on the falling end of the phase clock high time
        nxt_wr   = !s_cs_n && !s_rw && phase_d_ff && !s_ph;
        nxt_wdat = nxt_wr ? wdat_sync : wdat_ff;
        nxt_wsel = nxt_wr ? s_rs : wsel_ff;
    end

    always_ff @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_ff   <= TRHPS_IDLE;
            code_ff    <= `TRHPS_CODE_RST;
            est_ff     <= 1'b0;
            ds_ff      <= 1'b0;
            cnt_ff     <= 8'h00;
            wr_ff      <= 1'b0;
            phase_d_ff <= 1'b0;
            rdata_ff   <= 4'h0;
            wdat_ff    <= 4'h0;
            wsel_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            code_ff    <= nxt_code;
            est_ff     <= nxt_est;
            ds_ff      <= nxt_ds;
            cnt_ff     <= nxt_cnt;
            wr_ff      <= nxt_wr;
            phase_d_ff <= nxt_phase_d;
            rdata_ff   <= nxt_rdata;
            wdat_ff    <= nxt_wdat;
            wsel_ff    <= nxt_wsel;
        end
    end

    // bus drive is combinational on purpose: it must let go the moment
    // select or phase drops; the read value itself is registered
    assign host_data_nibble_out      = rdata_ff;
    assign host_data_nibble_oe_n_out = !(access && s_rw);
    assign host_write_data_out       = wdat_ff;
    assign host_write_strobe_out     = wr_ff;
    assign host_write_select_out     = wsel_ff;

    assign early_tone_detect_out = est_ff;
    assign delayed_steer_out     = ds_ff;
    // guard drive: high while detect high and sense above threshold, else low
    assign guard_time_drive_out  = est_ff && s_thr;
    assign steering_sense_guard_drive_oe_n_out = 1'b0;
    // open drain: 0 out with enable low pulls the pin; released reads high
    assign interrupt_or_tone_square_out = 1'b0;
    assign interrupt_or_tone_square_oe_n_out =
        !s_ien ? 1'b1 :
        s_cpm  ? s_sq :
                 !ds_ff;

    chk_est_follow: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (!s_valid || s_cpm) |=> !early_tone_detect_out)
        else $error("early detect not dropped");
    chk_est_rise: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (s_valid && !s_cpm) |=> early_tone_detect_out)
        else $error("early detect not raised");
    sequence reg_start_s;
        state_ff == TRHPS_IDLE && s_thr && !s_cpm;
    endsequence
    chk_reg_code: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        reg_start_s |=> code_ff == $past(code_sync))
        else $error("code not latched");
    chk_ds_delay: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        reg_start_s |=> !ds_ff ##[1:300] ds_ff)
        else $error("delayed flag late");
    chk_rearm: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (state_ff == TRHPS_HELD && !s_thr) |=>
        (state_ff == TRHPS_IDLE && !ds_ff))
        else $error("no rearm");
    chk_cpm_block: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (state_ff == TRHPS_IDLE && s_cpm) |=> state_ff == TRHPS_IDLE)
        else $error("registration in call progress");
    chk_bus_float: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (s_cs_n || !s_ph) |-> host_data_nibble_oe_n_out)
        else $error("bus driven when idle");
    chk_irq_level: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        (s_ien && !s_cpm && ds_ff) |-> !interrupt_or_tone_square_oe_n_out)
        else $error("interrupt not pulled");
    chk_wr_once: assert property (@(posedge clock_in)
        disable iff (!reset_n_in)
        host_write_strobe_out |=> !host_write_strobe_out)
        else $error("write strobe too long");
endmodule : trhps_top
`default_nettype wire

//--- verification/trhps_host_model.sv
// trhps_host_model.sv: host processor side of the nibble bus
// assumes: bench resolves the shared data wire from both enables
`default_nettype none
module trhps_host_model (
    input  wire logic       clock_in,
    input  wire logic [3:0] bus_in,
    output logic            rw_out,
    output logic            cs_n_out,
    output logic            rs_out,
    output logic            phase_out,
    output logic      [3:0] data_out,
    output logic            drive_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        rw_out = 1'b1;
        cs_n_out = 1'b1;
        rs_out = 1'b0;
        phase_out = 1'b0; // phase clock stands still when idle
        data_out = 4'h0;
        drive_out = 1'b0;
    end
    task automatic access(input logic rw, input logic cs_n, input logic rs,
                          input logic [3:0] d, output logic [3:0] q);
        @(posedge clock_in);
        #1;
        rw_out = rw;
        cs_n_out = cs_n;
        rs_out = rs;
        data_out = d;
        drive_out = !rw && !cs_n;
        phase_out = 1'b1;
        repeat (6) @(posedge clock_in);
        #1;
        q = bus_in; // read data valid late in the high phase
        phase_out = 1'b0; // write taken as phase falls
        repeat (4) @(posedge clock_in);
        #1;
        cs_n_out = 1'b1;
        drive_out = 1'b0;
        rw_out = 1'b1;
    endtask : access
endmodule : trhps_host_model
`default_nettype wire

//--- verification/trhps_top_tb.sv
// trhps_top_tb.sv: self-checking bench for the tone receiver host port
// assumes: design and host model compiled before this file
`default_nettype none
module trhps_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, rw, cs_n, rs, ph, hdrv, valid, sq, thr, cp, ien;
    logic [3:0] hdat, code, nib, last, dout, wdat, q;
    logic oe_n, early_tone_detect, gt, gt_oe_n, irq, irq_oe_n, dst, wstb, wsel, oe_seen;
    int n_errors, n_compared, n_strobe;
    assign nib = !oe_n ? dout : (hdrv ? hdat : ~last);
    trhps_top u_trhps_top (.clock_in(clk), .reset_n_in(rst_n),
        .read_not_write_in(rw), .chip_select_n_in(cs_n),
        .register_select_bit_in(rs), .phase_clock_in(ph),
        .host_data_nibble_in(nib), .host_data_nibble_out(dout),
        .host_data_nibble_oe_n_out(oe_n), .tone_pair_valid_in(valid),
        .tone_code_in(code), .tone_square_in(sq), .steering_threshold_in(thr),
        .early_tone_detect_out(early_tone_detect), .guard_time_drive_out(gt),
        .steering_sense_guard_drive_oe_n_out(gt_oe_n),
        .interrupt_or_tone_square_out(irq),
        .interrupt_or_tone_square_oe_n_out(irq_oe_n),
        .delayed_steer_out(dst), .host_write_data_out(wdat),
        .host_write_strobe_out(wstb), .host_write_select_out(wsel),
        .status_extra_in(4'h8), .call_progress_mode_in(cp),
        .interrupt_enable_in(ien));
    trhps_host_model u_trhps_host_model (.clock_in(clk), .bus_in(nib),
        .rw_out(rw), .cs_n_out(cs_n), .rs_out(rs), .phase_out(ph),
        .data_out(hdat), .drive_out(hdrv));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        last <= nib;
        if (wstb === 1'b1) n_strobe <= n_strobe + 1;
        if (oe_n !== 1'b1) oe_seen <= 1'b1;
    end
    task automatic chk(input logic [3:0] got, input logic [3:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task automatic stop_test;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test
    task automatic t_bus;
        u_trhps_host_model.access(1'b0, 1'b0, 1'b1, 4'hA, q);
        chk(4'(n_strobe), 4'h1);
        chk(wdat, 4'hA);
        chk({3'h0, wsel}, 4'h1);
        oe_seen = 1'b0;
        u_trhps_host_model.access(1'b0, 1'b1, 1'b0, 4'h5, q);
        u_trhps_host_model.access(1'b1, 1'b1, 1'b0, 4'h0, q);
        chk(4'(n_strobe), 4'h1);
        chk({3'h0, oe_seen}, 4'h0);
        wt(20);
        chk({3'h0, oe_seen}, 4'h0);
    endtask : t_bus
    task automatic t_steer;
        code = 4'h9;
        valid = 1'b1;
        wt(5);
        chk({2'h0, early_tone_detect, gt}, 4'h2);
        thr = 1'b1;
        wt(8);
        chk({dst, gt, irq_oe_n, irq}, 4'hC);
        chk({3'h0, gt_oe_n}, 4'h0);
        oe_seen = 1'b0;
        u_trhps_host_model.access(1'b1, 1'b0, 1'b0, 4'h0, q);
        chk(q, 4'h9);
        chk({3'h0, oe_seen}, 4'h1);
        chk(4'(n_strobe), 4'h1);
        u_trhps_host_model.access(1'b1, 1'b0, 1'b1, 4'h0, q);
        chk(q, 4'hE);
        valid = 1'b0;
        wt(5);
        chk({1'b0, early_tone_detect, gt, dst}, 4'h1);
        thr = 1'b0;
        wt(5);
        chk({2'h0, dst, irq_oe_n}, 4'h1);
        code = 4'h3;
        valid = 1'b1;
        wt(5);
        thr = 1'b1;
        wt(8);
        u_trhps_host_model.access(1'b1, 1'b0, 1'b0, 4'h0, q);
        chk(q, 4'h3);
        valid = 1'b0;
        thr = 1'b0;
        wt(6);
    endtask : t_steer
    task automatic t_cp;
        cp = 1'b1;
        valid = 1'b1;
        thr = 1'b1;
        sq = 1'b1;
        wt(10);
        chk({2'h0, early_tone_detect, dst}, 4'h0);
        chk({3'h0, irq_oe_n}, 4'h1);
        sq = 1'b0;
        wt(5);
        chk({3'h0, irq_oe_n}, 4'h0);
        ien = 1'b0;
        wt(5);
        chk({3'h0, irq_oe_n}, 4'h1);
    endtask : t_cp
    initial begin
        n_errors = 0;
        n_compared = 0;
        n_strobe = 0;
        last = 4'h0;
        oe_seen = 1'b0;
        rst_n = 1'b0;
        {valid, sq, thr, cp} = 4'h0;
        ien = 1'b1;
        code = 4'h0;
        wt(2);
        chk({oe_n, irq_oe_n, early_tone_detect, dst}, 4'hC);
        rst_n = 1'b1;
        wt(2);
        t_bus();
        t_steer();
        t_cp();
        stop_test();
    end
    initial begin
        #100us;
        n_errors++;
        stop_test();
    end
endmodule : trhps_top_tb
`default_nettype wire
